// *** cfep_core.sv ***
// Two-stage fetch/execute core with banked data addressing and table access.
// Assumes asynchronous program and data memories that answer within the same cycle.
`timescale 1ns/1ps
// Operation
// - Clock divided by four into four phase enables forming one instruction cycle.
// - Fetch: program counter advances in phase one, word captured in phase four.
// - Execute: instruction latched in phase one, executed over phases two to four.
// - Data operand read happens in phase two, destination write in phase four.
// - Fetch of next instruction overlaps execution of current one.
// - Program-flow changes flush the fetched word and take two cycles.
// - Program memory is byte addressed; instruction words start on even bytes.
// - Program counter steps by two and its lowest bit stays zero.
// - Absolute jump and call load a word address into counter bits 20:1.
// - Relative branch offsets count single-word instructions, two bytes each.
// - Four two-word instructions; second word marked by ones, low 12 bits data.
// - A second word executed on its own behaves as a no-operation.
// - Adding working register to counter low byte makes a computed jump.
// - Table access uses a byte pointer and one-byte latch, one byte each.
// - Data memory uses a 12-bit address, up to 4096 bytes.
// - Sixteen banks of 256 bytes chosen by four bank-select bits.
// - Core registers at top of last bank; unimplemented locations read zero.
// - Indirect pointers hold full 12-bit addresses independent of bank selection.
// - Register-to-register move is two words, two cycles, across any banks.
// - Access region in banks zero and fifteen reachable without bank selection.
// - Counter is 21 bits; data writes reach its upper bytes only through latch registers.
// - Writing low byte loads latches into counter; reading it fills latches.
module cfep_core
  import cfep_pkg::*;
#(
  parameter int RAM_BYTES = 3936 // General purpose RAM locations below the core registers
)
(
  input  wire logic               sys_clk,    // Oscillator input clock
  input  wire logic               rst_n,      // Synchronous reset, active low
  output logic [PC_W-1:0]         progAddr,   // Program memory fetch byte address
  input  wire logic [WORD_W-1:0]  progRdData, // Program word at progAddr
  output logic [PC_W-1:0]         tblAddr,    // Table access byte address
  input  wire logic [BYTE_W-1:0]  tblRdData,  // Program byte at tblAddr
  output logic [BYTE_W-1:0]       tblWrData,  // Byte to write at tblAddr
  output logic                    tblWrEn,    // Table write strobe
  output logic [DATA_AW-1:0]      dataRdAddr, // Data memory read address
  output logic                    dataRdEn,   // Data memory read strobe
  input  wire logic [BYTE_W-1:0]  dataRdData, // Data memory read byte
  output logic [DATA_AW-1:0]      dataWrAddr, // Data memory write address
  output logic [BYTE_W-1:0]       dataWrData, // Data memory write byte
  output logic                    dataWrEn,   // Data memory write strobe
  output logic [BYTE_W-1:0]       workingReg  // Working register value
);

  initial
  begin
    if (RAM_BYTES < 1 || RAM_BYTES > int'(SFR_BASE))
      $error("cfep_core: RAM_BYTES must lie between 1 and the core register base");
  end

  localparam logic [DATA_AW:0] RAM_LIMIT = (DATA_AW+1)'(RAM_BYTES);

  cfep_state_s q_ff;
  cfep_state_s nxt_q;
  logic        phaseOne;
  logic        phaseTwo;
  logic        phaseThree;
  logic        phaseFour;
  cfep_op_e    exOp;
  cfep_op_e    latchOp;

  cfep_phase_gen u_phase (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .phaseOne   (phaseOne),
    .phaseTwo   (phaseTwo),
    .phaseThree (phaseThree),
    .phaseFour  (phaseFour)
  );

  // Indirect operand addresses are replaced by the full pointer, so banking never applies.
  function automatic logic [DATA_AW-1:0] redirect(input logic [DATA_AW-1:0] a,
                                                   input cfep_state_s s);
    logic [DATA_AW-1:0] r;
    r = a;
    case (a)
      A_IND_OP0: r = s.ptr[0];
      A_IND_OP1: r = s.ptr[1];
      A_IND_OP2: r = s.ptr[2];
      default:   r = a;
    endcase
    return r;
  endfunction : redirect

  // Forms the 12-bit operand address of a single-word file instruction.
  function automatic logic [DATA_AW-1:0] file_addr(input logic [WORD_W-1:0] w,
                                                    input cfep_state_s s);
    logic [DATA_AW-1:0] a;
    if (w[8])
      a = {s.bankSel, w[7:0]};
    else if (w[7:0] < ACCESS_SPLIT)
      a = {LOW_BANK, w[7:0]};
    else
      a = {HIGH_BANK, w[7:0]};
    return redirect(a, s);
  endfunction : file_addr

  function automatic logic is_ext(input logic [DATA_AW-1:0] a);
    return {1'b0, a} < RAM_LIMIT;
  endfunction : is_ext

  // Read value of a data location: RAM below the limit, core registers, else zero.
  function automatic logic [BYTE_W-1:0] read_byte(input logic [DATA_AW-1:0] a,
                                                   input cfep_state_s s,
                                                   input logic [BYTE_W-1:0] ext);
    logic [BYTE_W-1:0] v;
    v = 8'h00;
    if (is_ext(a))
      v = ext;
    else
      case (a)
        A_WORKING:        v = s.working;
        A_BANK_SEL:       v = {4'h0, s.bankSel};
        A_STATUS:         v = {5'h00, s.zeroFlag, 2'h0};
        A_PTR0_L:         v = s.ptr[0][7:0];
        A_PTR0_H:         v = {4'h0, s.ptr[0][11:8]};
        A_PTR1_L:         v = s.ptr[1][7:0];
        A_PTR1_H:         v = {4'h0, s.ptr[1][11:8]};
        A_PTR2_L:         v = s.ptr[2][7:0];
        A_PTR2_H:         v = {4'h0, s.ptr[2][11:8]};
        A_PC_LOW_BYTE:    v = s.fetchAddr[7:0];
        A_PC_HIGH_LATCH:  v = s.pcHighLatch;
        A_PC_UPPER_LATCH: v = {3'h0, s.pcUpperLatch};
        A_TPTR_L:         v = s.tablePtr[7:0];
        A_TPTR_H:         v = s.tablePtr[15:8];
        A_TPTR_U:         v = {3'h0, s.tablePtr[20:16]};
        A_TABLE_LATCH:    v = s.tableLatch;
        default:          v = 8'h00;
      endcase
    return v;
  endfunction : read_byte

  assign exOp    = cfep_decode(q_ff.ir);
  assign latchOp = cfep_decode(q_ff.fetchWord);

  always_comb
  begin
    logic              flush;
    logic [BYTE_W-1:0] sum;
    nxt_q = q_ff;
    flush = 1'b0;
    sum   = 8'h00;

    if (phaseOne)
    begin
      nxt_q.fetchAddr = q_ff.pc;
      nxt_q.pc        = q_ff.pc + PC_STEP;
      nxt_q.ir        = q_ff.fetchWord;
      nxt_q.irValid   = q_ff.fetchValid;
      nxt_q.wrMem     = 1'b0;
      nxt_q.wrWorking = 1'b0;
      if (latchOp == OP_REG_TO_REG)
        nxt_q.rdAddr = redirect(q_ff.fetchWord[11:0], q_ff);
      else
        nxt_q.rdAddr = file_addr(q_ff.fetchWord, q_ff);
    end

    if (phaseTwo && q_ff.irValid)
    begin
      nxt_q.operand = read_byte(q_ff.rdAddr, q_ff, dataRdData);
      if (q_ff.rdAddr == A_PC_LOW_BYTE)
      begin
        nxt_q.pcHighLatch  = q_ff.fetchAddr[15:8];
        nxt_q.pcUpperLatch = q_ff.fetchAddr[20:16];
      end
    end

    if (phaseThree && q_ff.irValid)
    begin
      nxt_q.peek = progRdData;
      sum        = q_ff.operand + q_ff.working;
      case (exOp)
        OP_STORE_W:
        begin
          nxt_q.result = q_ff.working;
          nxt_q.wrAddr = q_ff.rdAddr;
          nxt_q.wrMem  = 1'b1;
        end
        OP_ADD_W_FILE, OP_COPY_FILE:
        begin
          nxt_q.result    = (exOp == OP_ADD_W_FILE) ? sum : q_ff.operand;
          nxt_q.wrAddr    = q_ff.rdAddr;
          nxt_q.wrMem     = q_ff.ir[9];
          nxt_q.wrWorking = ~q_ff.ir[9];
        end
        OP_REG_TO_REG:
        begin
          nxt_q.result = q_ff.operand;
          nxt_q.wrAddr = redirect(progRdData[11:0], q_ff);
          nxt_q.wrMem  = 1'b1;
        end
        default:
        begin
          nxt_q.result = q_ff.operand;
        end
      endcase
    end

    if (phaseFour)
    begin
      nxt_q.fetchWord = progRdData;
      if (q_ff.irValid)
      begin
        if (q_ff.wrWorking)
          nxt_q.working = q_ff.result;
        if (q_ff.wrWorking || (q_ff.wrMem && exOp != OP_STORE_W && exOp != OP_REG_TO_REG))
          nxt_q.zeroFlag = (q_ff.result == 8'h00);
        if (q_ff.wrMem && !is_ext(q_ff.wrAddr))
          case (q_ff.wrAddr)
            A_WORKING:        nxt_q.working = q_ff.result;
            A_BANK_SEL:       nxt_q.bankSel = q_ff.result[3:0];
            A_STATUS:         nxt_q.zeroFlag = q_ff.result[ZERO_BIT];
            A_PTR0_L:         nxt_q.ptr[0][7:0] = q_ff.result;
            A_PTR0_H:         nxt_q.ptr[0][11:8] = q_ff.result[3:0];
            A_PTR1_L:         nxt_q.ptr[1][7:0] = q_ff.result;
            A_PTR1_H:         nxt_q.ptr[1][11:8] = q_ff.result[3:0];
            A_PTR2_L:         nxt_q.ptr[2][7:0] = q_ff.result;
            A_PTR2_H:         nxt_q.ptr[2][11:8] = q_ff.result[3:0];
            A_PC_HIGH_LATCH:  nxt_q.pcHighLatch = q_ff.result;
            A_PC_UPPER_LATCH: nxt_q.pcUpperLatch = q_ff.result[4:0];
            A_TPTR_L:         nxt_q.tablePtr[7:0] = q_ff.result;
            A_TPTR_H:         nxt_q.tablePtr[15:8] = q_ff.result;
            A_TPTR_U:         nxt_q.tablePtr[20:16] = q_ff.result[4:0];
            A_TABLE_LATCH:    nxt_q.tableLatch = q_ff.result;
            A_PC_LOW_BYTE:
            begin
              // Computed jump: latches supply the upper bytes, bit zero stays clear.
              nxt_q.pc = {q_ff.pcUpperLatch, q_ff.pcHighLatch,
                          q_ff.result[7:1], 1'b0};
              flush    = 1'b1;
            end
            default:
            begin
            end
          endcase
        case (exOp)
          OP_LOAD_LIT: nxt_q.working = q_ff.ir[7:0];
          OP_SET_BANK: nxt_q.bankSel = q_ff.ir[3:0];
          OP_TEST_SKIP: flush = (q_ff.operand == 8'h00);
          OP_BRANCH_REL:
          begin
            nxt_q.pc = q_ff.fetchAddr + {{9{q_ff.ir[10]}}, q_ff.ir[10:0], 1'b0};
            flush    = 1'b1;
          end
          OP_JUMP_ABS, OP_CALL_ABS:
          begin
            nxt_q.pc = {q_ff.peek[11:0], q_ff.ir[7:0], 1'b0};
            flush    = 1'b1;
          end
          OP_LOAD_PTR_LIT:
          begin
            nxt_q.ptr[q_ff.ir[5:4]] = {q_ff.ir[3:0], q_ff.peek[7:0]};
            flush = 1'b1;
          end
          OP_REG_TO_REG: flush = 1'b1;
          OP_TABLE_READ, OP_TABLE_WRITE:
          begin
            if (exOp == OP_TABLE_READ)
              nxt_q.tableLatch = tblRdData;
            if (q_ff.ir[0])
              nxt_q.tablePtr = q_ff.tablePtr + 21'h000001;
          end
          default:
          begin
            // A lone second word decodes here and does nothing.
          end
        endcase
      end
      nxt_q.fetchValid = ~flush;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q_ff <= '0;
      q_ff.pc <= RST_PC;
    end
    else
      q_ff <= nxt_q;
  end

  // A pointer at index three selects no register, so that encoding is harmless.
  assign progAddr   = q_ff.fetchAddr;
  assign tblAddr    = q_ff.tablePtr;
  assign tblWrData  = q_ff.tableLatch;
  assign tblWrEn    = phaseFour && q_ff.irValid && exOp == OP_TABLE_WRITE;
  assign dataRdAddr = q_ff.rdAddr;
  assign dataRdEn   = phaseTwo && q_ff.irValid && is_ext(q_ff.rdAddr);
  assign dataWrAddr = q_ff.wrAddr;
  assign dataWrData = q_ff.result;
  assign dataWrEn   = phaseFour && q_ff.irValid && q_ff.wrMem && is_ext(q_ff.wrAddr);
  assign workingReg = q_ff.working;

endmodule : cfep_core

// *** cfep_pkg.sv ***
// Shared constants, opcode classes and the state record of the fetch/execute core.
// Assumes a single system clock; the instruction cycle is built from phase enables.
package cfep_pkg;

  localparam int PC_W      = 21;
  localparam int DATA_AW   = 12;
  localparam int WORD_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int BANK_W    = 4;
  localparam int NUM_PTR   = 3;
  localparam int PHASE_CNT = 4;
  localparam int ZERO_BIT  = 2;

  localparam logic [PC_W-1:0]    PC_STEP       = 21'h000002;
  localparam logic [PC_W-1:0]    RST_PC        = 21'h000000;
  localparam logic [BYTE_W-1:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [BANK_W-1:0]  LOW_BANK      = 4'h0;
  localparam logic [BANK_W-1:0]  HIGH_BANK     = 4'hf;
  localparam logic [DATA_AW-1:0] SFR_BASE      = 12'hf60;
  localparam logic [3:0]         SECOND_MARK   = 4'hf;

  // Core register addresses in the top of the last bank.
  localparam logic [DATA_AW-1:0] A_PC_UPPER_LATCH = 12'hffb;
  localparam logic [DATA_AW-1:0] A_PC_HIGH_LATCH  = 12'hffa;
  localparam logic [DATA_AW-1:0] A_PC_LOW_BYTE    = 12'hff9;
  localparam logic [DATA_AW-1:0] A_TPTR_U         = 12'hff8;
  localparam logic [DATA_AW-1:0] A_TPTR_H         = 12'hff7;
  localparam logic [DATA_AW-1:0] A_TPTR_L         = 12'hff6;
  localparam logic [DATA_AW-1:0] A_TABLE_LATCH    = 12'hff5;
  localparam logic [DATA_AW-1:0] A_IND_OP0        = 12'hfef;
  localparam logic [DATA_AW-1:0] A_PTR0_H         = 12'hfea;
  localparam logic [DATA_AW-1:0] A_PTR0_L         = 12'hfe9;
  localparam logic [DATA_AW-1:0] A_WORKING        = 12'hfe8;
  localparam logic [DATA_AW-1:0] A_IND_OP1        = 12'hfe7;
  localparam logic [DATA_AW-1:0] A_PTR1_H         = 12'hfe2;
  localparam logic [DATA_AW-1:0] A_PTR1_L         = 12'hfe1;
  localparam logic [DATA_AW-1:0] A_BANK_SEL       = 12'hfe0;
  localparam logic [DATA_AW-1:0] A_IND_OP2        = 12'hfdf;
  localparam logic [DATA_AW-1:0] A_PTR2_H         = 12'hfda;
  localparam logic [DATA_AW-1:0] A_PTR2_L         = 12'hfd9;
  localparam logic [DATA_AW-1:0] A_STATUS         = 12'hfd8;

  typedef enum {
    OP_NOP, OP_LOAD_LIT, OP_SET_BANK, OP_STORE_W, OP_ADD_W_FILE, OP_COPY_FILE,
    OP_TEST_SKIP, OP_BRANCH_REL, OP_JUMP_ABS, OP_CALL_ABS, OP_LOAD_PTR_LIT,
    OP_REG_TO_REG, OP_TABLE_READ, OP_TABLE_WRITE
  } cfep_op_e;

  typedef struct packed {
    logic [PC_W-1:0]                 pc;
    logic [PC_W-1:0]                 fetchAddr;
    logic [WORD_W-1:0]               fetchWord;
    logic                            fetchValid;
    logic [WORD_W-1:0]               ir;
    logic                            irValid;
    logic [WORD_W-1:0]               peek;
    logic [BYTE_W-1:0]               working;
    logic [BANK_W-1:0]               bankSel;
    logic [NUM_PTR-1:0][DATA_AW-1:0] ptr;
    logic [BYTE_W-1:0]               pcHighLatch;
    logic [4:0]                      pcUpperLatch;
    logic [PC_W-1:0]                 tablePtr;
    logic [BYTE_W-1:0]               tableLatch;
    logic                            zeroFlag;
    logic [DATA_AW-1:0]              rdAddr;
    logic [BYTE_W-1:0]               operand;
    logic [BYTE_W-1:0]               result;
    logic [DATA_AW-1:0]              wrAddr;
    logic                            wrMem;
    logic                            wrWorking;
  } cfep_state_s;

  // Classifies one instruction word; anything unknown runs as a no-operation.
  function automatic cfep_op_e cfep_decode(input logic [WORD_W-1:0] w);
    cfep_op_e op;
    op = OP_NOP;
    casez (w)
      16'h0f??: op = OP_LOAD_LIT;
      16'h010?: op = OP_SET_BANK;
      16'h0008, 16'h0009: op = OP_TABLE_READ;
      16'h000c, 16'h000d: op = OP_TABLE_WRITE;
      16'b0110_111?_????_????: op = OP_STORE_W;
      16'b0010_01??_????_????: op = OP_ADD_W_FILE;
      16'b0101_00??_????_????: op = OP_COPY_FILE;
      16'b0110_011?_????_????: op = OP_TEST_SKIP;
      16'b1101_0???_????_????: op = OP_BRANCH_REL;
      16'hef??: op = OP_JUMP_ABS;
      16'b1110_110?_????_????: op = OP_CALL_ABS;
      16'b1110_1110_00??_????: op = OP_LOAD_PTR_LIT;
      16'hc???: op = OP_REG_TO_REG;
      default: op = OP_NOP;
    endcase
    return op;
  endfunction : cfep_decode

endpackage : cfep_pkg

// *** cfep_phase_gen.sv ***
// Divides the system clock into four one-cycle phase enables, one after another.
// Assumes the oscillator input is the system clock itself.
`timescale 1ns/1ps
module cfep_phase_gen
  import cfep_pkg::*;
(
  input  wire logic sys_clk,    // Oscillator input clock
  input  wire logic rst_n,      // Synchronous reset, active low
  output logic      phaseOne,   // First phase enable
  output logic      phaseTwo,   // Second phase enable
  output logic      phaseThree, // Third phase enable
  output logic      phaseFour   // Fourth phase enable
);

  logic [PHASE_CNT-1:0] ring_ff;
  logic [PHASE_CNT-1:0] nxt_ring;

  // Reset parks the ring on the fourth phase so the first edge after release is phase one.
  always_comb
  begin
    nxt_ring = {ring_ff[PHASE_CNT-2:0], ring_ff[PHASE_CNT-1]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ring_ff <= 4'h8;
    else
      ring_ff <= nxt_ring;
  end

  assign phaseOne   = ring_ff[0];
  assign phaseTwo   = ring_ff[1];
  assign phaseThree = ring_ff[2];
  assign phaseFour  = ring_ff[3];

endmodule : cfep_phase_gen

// *** cfep_core_properties.sv ***
// Checker for the fetch/execute core: phase placement of strobes and address holding.
// Assumes it is bound to cfep_core and sees only that module's ports.
`timescale 1ns/1ps
module cfep_core_properties
  import cfep_pkg::*;
#(
  parameter int RAM_BYTES = 3936 // General purpose RAM locations
)
(
  input wire logic [0:0]         sys_clk,    // Oscillator input clock
  input wire logic               rst_n,      // Synchronous reset, active low
  input wire logic [PC_W-1:0]    progAddr,   // Fetch byte address
  input wire logic               tblWrEn,    // Table write strobe
  input wire logic [DATA_AW-1:0] dataRdAddr, // Data read address
  input wire logic               dataRdEn,   // Data read strobe
  input wire logic [DATA_AW-1:0] dataWrAddr, // Data write address
  input wire logic [BYTE_W-1:0]  dataWrData, // Data write byte
  input wire logic               dataWrEn    // Data write strobe
);
  // Phase of the current cycle, zero for phase one; reset value makes the first cycle phase one.
  logic [1:0] phase_ff;

  always_ff @(posedge sys_clk)
    phase_ff <= rst_n ? phase_ff + 2'h1 : 2'h3;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence quietWrite;
    !dataWrEn [*3];
  endsequence
  sequence quietTable;
    !tblWrEn [*3];
  endsequence

  // A register loaded on the edge that ends a phase is first seen changed one tick later,
  // so each hold check lets its address move only at the tick that samples the next phase.
  rd_phase_two_a: assert property (dataRdEn |-> phase_ff == 2'h1)
    else $error("data read outside phase two");
  wr_phase_four_a: assert property (dataWrEn |-> phase_ff == 2'h3)
    else $error("data write outside phase four");
  tbl_phase_four_a: assert property (tblWrEn |-> phase_ff == 2'h3)
    else $error("table write outside phase four");
  wr_single_a: assert property (dataWrEn |=> quietWrite)
    else $error("more than one data write in an instruction cycle");
  tbl_single_a: assert property (tblWrEn |=> quietTable)
    else $error("more than one table write in an instruction cycle");
  fetch_even_a: assert property (progAddr[0] == 1'b0)
    else $error("odd fetch address");
  fetch_hold_a: assert property (phase_ff != 2'h1 |-> $stable(progAddr))
    else $error("fetch address moved outside phase one");
  rd_addr_hold_a: assert property (phase_ff != 2'h1 |-> $stable(dataRdAddr))
    else $error("read address moved outside phase one");
  wr_addr_hold_a: assert property (phase_ff != 2'h3 |-> $stable({dataWrAddr, dataWrData}))
    else $error("write address moved outside phase three");
  wr_range_a: assert property (dataWrEn |-> dataWrAddr < RAM_BYTES)
    else $error("write strobed into register space");
  rd_range_a: assert property (dataRdEn |-> dataRdAddr < RAM_BYTES)
    else $error("read strobed into register space");
endmodule : cfep_core_properties

bind cfep_core cfep_core_properties #(.RAM_BYTES(RAM_BYTES)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .progAddr(progAddr), .tblWrEn(tblWrEn),
  .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn), .dataWrAddr(dataWrAddr),
  .dataWrData(dataWrData), .dataWrEn(dataWrEn));

// *** cfep_mem_model.sv ***
// Behavioural program memory and data RAM facing the core.
// Assumes reads answer combinationally and writes land on the clock edge that ends the strobe.
`timescale 1ns/1ps
module cfep_mem_model
  import cfep_pkg::*;
(
  input  wire logic               sys_clk,    // Clock
  input  wire logic [PC_W-1:0]    progAddr,   // Fetch byte address
  output logic [WORD_W-1:0]       progRdData, // Fetched word
  input  wire logic [PC_W-1:0]    tblAddr,    // Table byte address
  output logic [BYTE_W-1:0]       tblRdData,  // Table byte
  input  wire logic [BYTE_W-1:0]  tblWrData,  // Table write byte
  input  wire logic               tblWrEn,    // Table write strobe
  input  wire logic [DATA_AW-1:0] dataRdAddr, // Data read address
  input  wire logic               dataRdEn,   // Data read strobe
  output logic [BYTE_W-1:0]       dataRdData, // Data read byte
  input  wire logic [DATA_AW-1:0] dataWrAddr, // Data write address
  input  wire logic [BYTE_W-1:0]  dataWrData, // Data write byte
  input  wire logic               dataWrEn    // Data write strobe
);
  logic [WORD_W-1:0] progMem [0:255];
  logic [BYTE_W-1:0] dataMem [0:4095];
  logic [BYTE_W-1:0] lastRd_ff;

  initial
  begin
    lastRd_ff = 8'h00;
    for (int i = 0; i < 256; i++) progMem[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) dataMem[i] = 8'h00;
  end

  assign progRdData = progMem[progAddr[8:1]];
  assign tblRdData  = progMem[tblAddr[8:1]][8*tblAddr[0] +: 8];
  // An idle read line shows the inverse of its last value, so stale data is never taken as fresh.
  assign dataRdData = dataRdEn ? dataMem[dataRdAddr] : ~lastRd_ff;

  always @(posedge sys_clk)
  begin
    if (dataRdEn) lastRd_ff <= dataMem[dataRdAddr];
    if (dataWrEn) dataMem[dataWrAddr] <= dataWrData;
    if (tblWrEn) progMem[tblAddr[8:1]][8*tblAddr[0] +: 8] <= tblWrData;
  end
endmodule : cfep_mem_model

// *** testbench.sv ***
// Self-checking bench for the fetch/execute core: runs one program twice across resets.
// Assumes the memory model is loaded by hierarchical reference before reset is released.
`timescale 1ns/1ps
module testbench;
  import cfep_pkg::*;
  logic               sys_clk = 1'b0;
  logic               rst_n   = 1'b0;
  logic [PC_W-1:0]    progAddr, tblAddr;
  logic [WORD_W-1:0]  progRdData;
  logic [BYTE_W-1:0]  tblRdData, tblWrData, dataRdData, dataWrData, workingReg, rnd;
  logic               tblWrEn, dataRdEn, dataWrEn;
  logic [DATA_AW-1:0] dataRdAddr, dataWrAddr;
  int                 bad_count = 0;
  int                 samples_checked = 0;
  logic [29:0]        expQ [$];
  logic [15:0]        prog [0:31] = '{
    16'h0f55, 16'h6e10, 16'h0f00, 16'h0103, 16'h6f20, 16'hd001, 16'h6e11, 16'h6e12,
    16'hef0b, 16'hf000, 16'h6e11, 16'h6600, 16'hc123, 16'hf456, 16'hc010, 16'hf030,
    16'hee03, 16'hf040, 16'h6eef, 16'h0f04, 16'h26f9, 16'h6e14, 16'h6e14, 16'h0f01,
    16'h6ef6, 16'h6ef7, 16'h0009, 16'h50f5, 16'h6e13, 16'h000c, 16'hed1e, 16'hf000};

  cfep_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .progAddr(progAddr),
    .progRdData(progRdData), .tblAddr(tblAddr), .tblRdData(tblRdData),
    .tblWrData(tblWrData), .tblWrEn(tblWrEn), .dataRdAddr(dataRdAddr),
    .dataRdEn(dataRdEn), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn), .workingReg(workingReg));
  cfep_mem_model i_mem (.sys_clk(sys_clk), .progAddr(progAddr), .progRdData(progRdData),
    .tblAddr(tblAddr), .tblRdData(tblRdData), .tblWrData(tblWrData), .tblWrEn(tblWrEn),
    .dataRdAddr(dataRdAddr), .dataRdEn(dataRdEn), .dataRdData(dataRdData),
    .dataWrAddr(dataWrAddr), .dataWrData(dataWrData), .dataWrEn(dataWrEn));

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [29:0] seen, input logic [29:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      bad_count++;
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic note(input logic t, input logic [20:0] a, input logic [7:0] d);
    expQ.push_back({t, a, d});
  endtask : note

  // Mid-cycle sampling sees each one-cycle strobe exactly once and only settled values.
  always @(negedge sys_clk)
  begin
    logic [29:0] seen;
    seen = tblWrEn ? {1'b1, tblAddr, tblWrData} : {1'b0, 9'h000, dataWrAddr, dataWrData};
    if (rst_n && (dataWrEn || tblWrEn))
      check(seen, (expQ.size() > 0) ? expQ.pop_front() : ~seen);
  end

  initial
  begin
    int i;
    // The memory model clears its arrays at time zero, so the program is loaded after that.
    #1;
    void'($urandom(39));
    rnd = 8'($urandom());
    prog[2] = {8'h0f, rnd};
    for (i = 0; i < 32; i++) i_mem.progMem[i] = prog[i];
    i_mem.progMem[8'h80] = 16'habcd;
    for (int pass = 0; pass < 2; pass++)
    begin
      @(posedge sys_clk);
      #1 rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      note(1'b0, 21'h010, 8'h55);
      note(1'b0, 21'h320, rnd);
      note(1'b0, 21'h012, rnd);
      note(1'b0, 21'h030, 8'h55);
      note(1'b0, 21'h340, rnd);
      note(1'b0, 21'h013, 8'hab);
      note(1'b1, 21'h102, 8'hab);
      for (i = 0; i < 600 && expQ.size() > 0; i++) @(posedge sys_clk);
      // A timeout counts once and drops its leftover notes, so the next pass starts clean.
      if (expQ.size() > 0)
      begin
        bad_count++;
        expQ.delete();
      end
      repeat (40) @(posedge sys_clk);
      #2 check({22'h0, workingReg}, {22'h0, 8'hab});
      check({9'h0, tblAddr}, {9'h0, 21'h000102});
    end
    close_out();
  end
endmodule : testbench
